// ---- src/mkc_keypad_ctrl.sv ----
// Purpose: keypad decoder and mode flag store for a two-channel tone modem
// Assumes: key strobes from same clock; data and option pins are asynchronous
// Notes: numeric entry of frequencies and baud lives elsewhere
`timescale 1ns/1ps
`default_nettype none
`include "mkc_cfg.svh"
module mkc_keypad_ctrl
  import mkc_pkg::*;
#(
  parameter int KEYLINE_CYC = `MKC_KEYLINE_CYC,
  parameter int FLASH_CYC   = `MKC_FLASH_CYC
) (
  // clock and reset
  input  wire logic       CLK_IN,
  input  wire logic       SYS_RST_IN,
  // keypad
  input  wire logic       KEY_STB_IN,
  input  wire logic [4:0] KEY_CODE_IN,
  // options and data
  input  wire logic       DIV_FITTED_IN,
  input  wire logic       TX_DATA_IN,
  input  wire logic       TX_ACTIVE_IN,
  input  wire logic       RX_DEMOD_IN,
  input  wire logic       RX_CLK_IN,
  // storage and copy
  output logic            NV_SAVE_OUT,
  output logic            COPY_STB_OUT,
  output logic            COPY_FROM_PATH_SELECT_KEY_OUT,
  output logic            RESTORE_STB_OUT,
  // indicators
  output logic            TWO_TONE_DISCRIMINATOR_OUT,
  output logic            FIRST_TONE_ONLY_INDICATOR_OUT,
  output logic            SECOND_TONE_ONLY_INDICATOR_OUT,
  output logic            DIV_LED_OUT,
  output logic            MUTE_LED_OUT,
  output logic            REMOTE_LED_OUT,
  output logic            AUTO_IDLE_HOLD_OUT,
  output logic            HOLD_LED_OUT,
  output logic            INVERTED_POLARITY_OUT,
  output logic            RECLOCKED_RECEIVE_MODE_OUT,
  output logic            CHARACTER_REBUILD_MODE_OUT,
  output logic            CONFIRM_LED_OUT,
  output logic            CHAN2_OUT,
  // prompt display
  output logic            WLEN_PROMPT_OUT,
  output logic [3:0]      WLEN_BITS_OUT,
  // datapath
  output logic            TX_TONE_EN_OUT,
  output logic            TX_TONE_MARK_OUT,
  output logic            KEYLINE_OUT,
  output logic            RX_DATA_OUT,
  output logic            RX_INV_OUT
);

  mkc_state_s q;
  mkc_state_s d;
  logic [1:0] div_s;
  logic [1:0] txd_s;
  logic [1:0] txa_s;
  logic [1:0] rxd_s;
  logic [1:0] rxc_s;

  function automatic mkc_set_s set_reset();
    mkc_set_s s;
    s = '0;
    s.demod = DM_TWO_TONE;
    s.wlen  = `MKC_WLEN_RST;
    return s;
  endfunction

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      div_s <= 2'h0;
      txd_s <= 2'h0;
      txa_s <= 2'h0;
      rxd_s <= 2'h0;
      rxc_s <= 2'h0;
    end else begin
      div_s <= {div_s[0], DIV_FITTED_IN};
      txd_s <= {txd_s[0], TX_DATA_IN};
      txa_s <= {txa_s[0], TX_ACTIVE_IN};
      rxd_s <= {rxd_s[0], RX_DEMOD_IN};
      rxc_s <= {rxc_s[0], RX_CLK_IN};
    end
  end

  always_comb begin
    logic c;
    logic k;
    c = 1'b0;
    k = 1'b0;
    d = q;
    c = q.path_select_key;
    d.save = 1'b0;
    d.copy = 1'b0;
    k = KEY_STB_IN && (!q.remote || KEY_CODE_IN == `MKC_KEY_REMOTE);
    if (k) begin
      d.prefix = 1'b0;
      case (KEY_CODE_IN)
        `MKC_KEY_PREFIX: begin
          d.prefix = 1'b1;
        end
        `MKC_KEY_REMOTE: begin
          d.remote = !q.remote;
          d.save   = 1'b1;
        end
        `MKC_KEY_DISC: begin
          d.live.demod = DM_TWO_TONE;
          d.pend = 1'b1;
        end
        `MKC_KEY_MARK: begin
          if (q.prefix) begin
            d.live.demod = DM_MARK_ONLY;
            d.pend = 1'b1;
          end
        end
        `MKC_KEY_SPACE: begin
          if (q.prefix) begin
            d.live.demod = DM_SPACE_ONLY;
            d.pend = 1'b1;
          end
        end
        `MKC_KEY_DIV: begin
          if (div_s[1]) begin
            d.live.div = !q.live.div;
            d.pend = 1'b1;
          end
        end
        `MKC_KEY_MUTE: begin
          d.live.mute = !q.live.mute;
          d.pend = 1'b1;
        end
        `MKC_KEY_HOLD: begin
          if (q.prefix) d.live.hold[c] = !q.live.hold[c];
          else d.live.idle_hold = !q.live.idle_hold;
          d.pend = 1'b1;
        end
        `MKC_KEY_POL: begin
          d.live.inv[c] = q.prefix;
          d.pend = 1'b1;
        end
        `MKC_KEY_SYNC: begin
          if (q.prefix) begin
            d.live.rebuild = !q.live.rebuild;
            if (!q.live.rebuild) begin
              d.live.reclock = 1'b0;
              d.prompt = 1'b1;
            end
          end else begin
            d.live.reclock = !q.live.reclock;
            d.prompt = q.live.reclock;
          end
          d.pend = 1'b1;
        end
        `MKC_KEY_PATH_SELECT_KEY: begin
          if (q.prefix) begin
            d.copy = 1'b1;
            d.live.hold[!c] = q.live.hold[c];
            d.live.inv[!c]  = q.live.inv[c];
            d.pend = 1'b1;
          end else begin
            d.path_select_key = !q.path_select_key;
            d.save = 1'b1;
          end
        end
        `MKC_KEY_ENTER: begin
          if (q.pend || q.prompt) begin
            d.saved  = q.live;
            d.save   = 1'b1;
            d.pend   = 1'b0;
            d.prompt = 1'b0;
            d.flc    = 32'(FLASH_CYC);
          end
        end
        `MKC_KEY_CLEAR: begin
          if (q.pend || q.prompt) begin
            d.live   = q.saved;
            d.pend   = 1'b0;
            d.prompt = 1'b0;
          end
        end
        default: begin
          if (q.prompt && KEY_CODE_IN >= `MKC_KEY_D5 && KEY_CODE_IN <= `MKC_KEY_D8)
            d.live.wlen = 2'(KEY_CODE_IN - `MKC_KEY_D5);
        end
      endcase
    end
    if (q.flc != 32'h0) d.flc = q.flc - 32'h1;
    // keyline hang timer
    if (txa_s[1]) begin
      d.tx_on = 1'b1;
      d.klc   = 32'(KEYLINE_CYC);
    end else if (q.klc != 32'h0) begin
      d.klc = q.klc - 32'h1;
    end else begin
      d.tx_on = 1'b0;
    end
    d.tx_s0 = txd_s[1];
    d.tx_s1 = q.tx_s0;
    d.rx_s  = {q.rx_s[0], rxc_s[1]};
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      q       <= '0;
      q.live  <= set_reset();
      q.saved <= set_reset();
    end else begin
      q <= d;
    end
  end

  logic rx_bit_q;
  logic rx_raw;
  assign rx_raw = q.live.hold[0] ? 1'b1 : rxd_s[1];
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) rx_bit_q <= 1'b1;
    else if (!q.live.reclock || (q.rx_s == 2'b01)) rx_bit_q <= rx_raw;
  end

  always_comb begin
    NV_SAVE_OUT                    = q.save;
    COPY_STB_OUT                   = q.copy;
    COPY_FROM_PATH_SELECT_KEY_OUT             = q.path_select_key;
    RESTORE_STB_OUT                = 1'b0;
    TWO_TONE_DISCRIMINATOR_OUT     = q.live.demod == DM_TWO_TONE;
    FIRST_TONE_ONLY_INDICATOR_OUT  = q.live.demod == DM_MARK_ONLY;
    SECOND_TONE_ONLY_INDICATOR_OUT = q.live.demod == DM_SPACE_ONLY;
    DIV_LED_OUT                    = q.live.div;
    MUTE_LED_OUT                   = q.live.mute;
    REMOTE_LED_OUT                 = q.remote;
    AUTO_IDLE_HOLD_OUT             = q.live.idle_hold;
    HOLD_LED_OUT                   = q.live.hold[q.path_select_key];
    INVERTED_POLARITY_OUT          = q.live.inv[q.path_select_key];
    RECLOCKED_RECEIVE_MODE_OUT     = q.live.reclock;
    CHARACTER_REBUILD_MODE_OUT     = q.live.rebuild;
    CONFIRM_LED_OUT                = q.pend || q.prompt || q.flc[22];
    CHAN2_OUT                      = q.path_select_key;
    WLEN_PROMPT_OUT                = q.prompt || (q.flc != 32'h0);
    WLEN_BITS_OUT                  = 4'h5 + {2'h0, q.live.wlen};
    KEYLINE_OUT                    = q.tx_on;
    TX_TONE_EN_OUT                 = q.tx_on && !q.live.mute;
    TX_TONE_MARK_OUT               = q.live.hold[1] ? 1'b1 : (q.tx_s1 ^ q.live.inv[1]);
    RX_DATA_OUT                    = rx_bit_q;
    RX_INV_OUT                     = q.live.inv[0];
  end

endmodule
`default_nettype wire

// ---- src/mkc_cfg.svh ----
// Purpose: constants for the modem keypad mode control block
// Assumes: key codes arrive as one-cycle strobes with a 5-bit code
// Notes: counts derived from the 20 MHz system clock
// Overview of operation
// - prefix then space: single space-tone mode
// - diversity key toggles diversity flag and lamp
// - no diversity option: diversity key ignored
// - mute toggles; tones off, keyline unaffected
// - unmuted: tones drop with keyline after delay
// - remote key toggles; remote ignores other keys
// - remote change saved to storage at once
// - auto-hold key toggles idle hold flag
// - prefix hold toggles selected channel mark hold
// - upright key sets channel polarity normal
// - prefix reverse sets channel polarity inverted
// - sync key toggles reclocked receive mode
// - reclock off prompts word length 5 to 8
// - prefix rebuild toggles rebuild; turning it on clears reclock
// - digits 5-8 set length; confirm saves now
// - channel key alternates channel, saved at once
// - prefix channel copies settings to other channel
// - other mode changes saved only on confirm
// - prefix applies only to its defined keys
// - discriminator key selects two-tone mode
// - clear while pending restores saved settings
`ifndef MKC_CFG_SVH
`define MKC_CFG_SVH
`define MKC_KEY_D0       5'h00
`define MKC_KEY_D5       5'h05
`define MKC_KEY_D8       5'h08
`define MKC_KEY_PREFIX   5'h0a
`define MKC_KEY_MARK     5'h0b
`define MKC_KEY_SPACE    5'h0c
`define MKC_KEY_DISC     5'h0d
`define MKC_KEY_DIV      5'h0e
`define MKC_KEY_MUTE     5'h0f
`define MKC_KEY_REMOTE   5'h10
`define MKC_KEY_HOLD     5'h11
`define MKC_KEY_POL      5'h12
`define MKC_KEY_SYNC     5'h13
`define MKC_KEY_PATH_SELECT_KEY     5'h14
`define MKC_KEY_ENTER    5'h15
`define MKC_KEY_CLEAR    5'h16
`define MKC_KEY_BIT      5'h17
`define MKC_KEY_MSCENT   5'h18
`define MKC_WLEN_RST     2'h3
`define MKC_KEYLINE_MS   1000
`define MKC_CLK_KHZ      20000
`define MKC_KEYLINE_CYC  (`MKC_KEYLINE_MS * `MKC_CLK_KHZ)
`define MKC_FLASH_NS     500000000
`define MKC_FLASH_CYC    (`MKC_FLASH_NS / 50)
`endif

// ---- src/mkc_pkg.sv ----
// Purpose: types for the modem keypad mode control block
// Assumes: nothing beyond the constants header
// Notes: demodulator mode and settings snapshot
package mkc_pkg;
  typedef enum logic [1:0] {DM_TWO_TONE, DM_MARK_ONLY, DM_SPACE_ONLY} mkc_demod_e;
  typedef struct packed {
    mkc_demod_e demod;
    logic       div;
    logic       mute;
    logic       idle_hold;
    logic [1:0] hold;
    logic [1:0] inv;
    logic       reclock;
    logic       rebuild;
    logic [1:0] wlen;
  } mkc_set_s;
  typedef struct packed {
    mkc_set_s    live;
    mkc_set_s    saved;
    logic        prefix;
    logic        remote;
    logic        path_select_key;
    logic        pend;
    logic        prompt;
    logic        save;
    logic        copy;
    logic        tx_on;
    logic [31:0] klc;
    logic [31:0] flc;
    logic [1:0]  rx_s;
    logic        tx_s0;
    logic        tx_s1;
  } mkc_state_s;
endpackage

// ---- sim/mkc_keypad_asserts.sv ----
// Purpose: key to flag checks for the keypad control
// Assumes: bound to the top module
// Notes: prefix state rebuilt from key strobes
`timescale 1ns/1ps
`default_nettype none
`include "mkc_cfg.svh"
module mkc_keypad_asserts (
  // clock, reset, keys
  input wire logic       CLK_IN,
  input wire logic       SYS_RST_IN,
  input wire logic       KEY_STB_IN,
  input wire logic [4:0] KEY_CODE_IN,
  input wire logic       DIV_FITTED_IN,
  // outputs watched
  input wire logic       NV_SAVE_OUT,
  input wire logic       TWO_TONE_DISCRIMINATOR_OUT,
  input wire logic       FIRST_TONE_ONLY_INDICATOR_OUT,
  input wire logic       SECOND_TONE_ONLY_INDICATOR_OUT,
  input wire logic       DIV_LED_OUT,
  input wire logic       MUTE_LED_OUT,
  input wire logic       REMOTE_LED_OUT,
  input wire logic       AUTO_IDLE_HOLD_OUT,
  input wire logic       CHAN2_OUT
);
  logic       pre_q;
  logic       pre_d;
  logic       loc;
  logic [4:0] k;
  assign k = KEY_CODE_IN;
  assign loc = KEY_STB_IN && !REMOTE_LED_OUT && !pre_q;
  always_comb begin
    pre_d = pre_q;
    if (KEY_STB_IN && (!REMOTE_LED_OUT || k == `MKC_KEY_REMOTE)) begin
      pre_d = !REMOTE_LED_OUT && k == `MKC_KEY_PREFIX;
    end
  end
  always_ff @(posedge CLK_IN) begin
    pre_q <= SYS_RST_IN ? 1'b0 : pre_d;
  end
  default clocking dcb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  property p_space;
    KEY_STB_IN && pre_q && !REMOTE_LED_OUT && k == `MKC_KEY_SPACE |=> SECOND_TONE_ONLY_INDICATOR_OUT
      && !TWO_TONE_DISCRIMINATOR_OUT && !FIRST_TONE_ONLY_INDICATOR_OUT;
  endproperty
  a_space: assert property (p_space) else $error("space tone mode wrong");
  property p_div;
    loc && k == `MKC_KEY_DIV && DIV_FITTED_IN && $past(DIV_FITTED_IN, 4) |=> DIV_LED_OUT != $past(DIV_LED_OUT);
  endproperty
  a_div: assert property (p_div) else $error("diversity not toggled");
  property p_nodiv;
    KEY_STB_IN && k == `MKC_KEY_DIV && !DIV_FITTED_IN && !$past(DIV_FITTED_IN, 4) |=> $stable(DIV_LED_OUT);
  endproperty
  a_nodiv: assert property (p_nodiv) else $error("diversity changed without option");
  property p_mute;
    loc && k == `MKC_KEY_MUTE |=> MUTE_LED_OUT != $past(MUTE_LED_OUT) && !NV_SAVE_OUT;
  endproperty
  a_mute: assert property (p_mute) else $error("mute toggle wrong");
  property p_rem;
    KEY_STB_IN && REMOTE_LED_OUT && k != `MKC_KEY_REMOTE |=>
      $stable({DIV_LED_OUT, MUTE_LED_OUT, CHAN2_OUT, AUTO_IDLE_HOLD_OUT});
  endproperty
  a_rem: assert property (p_rem) else $error("key acted in remote");
  property p_remsave;
    KEY_STB_IN && !pre_q && k == `MKC_KEY_REMOTE |=> REMOTE_LED_OUT != $past(REMOTE_LED_OUT) && NV_SAVE_OUT;
  endproperty
  a_remsave: assert property (p_remsave) else $error("remote change not saved");
  property p_path_select_key;
    loc && k == `MKC_KEY_PATH_SELECT_KEY |=> CHAN2_OUT != $past(CHAN2_OUT) && NV_SAVE_OUT;
  endproperty
  a_path_select_key: assert property (p_path_select_key) else $error("channel change not saved");
  property p_aih;
    loc && k == `MKC_KEY_HOLD |=> AUTO_IDLE_HOLD_OUT != $past(AUTO_IDLE_HOLD_OUT) && !NV_SAVE_OUT;
  endproperty
  a_aih: assert property (p_aih) else $error("idle hold toggle wrong");
endmodule
`default_nettype wire

// ---- sim/mkc_operator.sv ----
// Purpose: operator pressing front panel keys
// Assumes: one strobe cycle per press
// Notes: code held at the complement of the last key between presses
`timescale 1ns/1ps
`default_nettype none
module mkc_operator (
  // keypad side
  input  wire logic       CLK_IN,
  output logic            KEY_STB_OUT,
  output logic [4:0]      KEY_CODE_OUT
);
  initial begin
    KEY_STB_OUT = 1'b0;
    KEY_CODE_OUT = 5'h1f;
  end
  task automatic press(input logic [4:0] code);
    @(posedge CLK_IN);
    KEY_STB_OUT <= 1'b1;
    KEY_CODE_OUT <= code;
    @(posedge CLK_IN);
    KEY_STB_OUT <= 1'b0;
    KEY_CODE_OUT <= ~code;
  endtask
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// Purpose: random key presses against a flag model
// Assumes: confirm never pressed, so only immediate saves
// Notes: transmit held active, keyline stays closed
`timescale 1ns/1ps
`default_nettype none
`include "mkc_cfg.svh"
module tb;
  logic       clk, rst, fit, txa, txd, rxd, rxc, stb, nv, two, one, sp, dvl, mul, rml, aih, c2o, ten, kl;
  logic [4:0] code;
  logic       dv, mu, ah, rm, c2, ex_nv;
  logic [1:0] dm;
  int         bad_count = 0;
  int         checked = 0;
  int         cyc = 0;
  logic [4:0] keys [7] = '{`MKC_KEY_DIV, `MKC_KEY_MUTE, `MKC_KEY_REMOTE, `MKC_KEY_HOLD, `MKC_KEY_PATH_SELECT_KEY,
                           `MKC_KEY_DISC, `MKC_KEY_SPACE};
  mkc_operator i_op (.CLK_IN(clk), .KEY_STB_OUT(stb), .KEY_CODE_OUT(code));
  mkc_keypad_ctrl #(.KEYLINE_CYC(10), .FLASH_CYC(8)) i_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .KEY_STB_IN(stb),
    .KEY_CODE_IN(code), .DIV_FITTED_IN(fit), .TX_DATA_IN(txd), .TX_ACTIVE_IN(txa), .RX_DEMOD_IN(rxd),
    .RX_CLK_IN(rxc), .NV_SAVE_OUT(nv), .COPY_STB_OUT(), .COPY_FROM_PATH_SELECT_KEY_OUT(), .RESTORE_STB_OUT(),
    .TWO_TONE_DISCRIMINATOR_OUT(two), .FIRST_TONE_ONLY_INDICATOR_OUT(one), .SECOND_TONE_ONLY_INDICATOR_OUT(sp),
    .DIV_LED_OUT(dvl), .MUTE_LED_OUT(mul), .REMOTE_LED_OUT(rml), .AUTO_IDLE_HOLD_OUT(aih), .HOLD_LED_OUT(),
    .INVERTED_POLARITY_OUT(), .RECLOCKED_RECEIVE_MODE_OUT(), .CHARACTER_REBUILD_MODE_OUT(), .CONFIRM_LED_OUT(),
    .CHAN2_OUT(c2o), .WLEN_PROMPT_OUT(), .WLEN_BITS_OUT(), .TX_TONE_EN_OUT(ten), .TX_TONE_MARK_OUT(),
    .KEYLINE_OUT(kl), .RX_DATA_OUT(), .RX_INV_OUT());
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic hit(input logic [4:0] c);
    if (c == `MKC_KEY_SPACE) i_op.press(`MKC_KEY_PREFIX);
    i_op.press(c);
    ex_nv = 1'b0;
    if (c == `MKC_KEY_REMOTE) begin
      rm = !rm;
      ex_nv = 1'b1;
    end else if (!rm) begin
      case (c)
        `MKC_KEY_DIV: dv = fit ? !dv : dv;
        `MKC_KEY_MUTE: mu = !mu;
        `MKC_KEY_HOLD: ah = !ah;
        `MKC_KEY_PATH_SELECT_KEY: begin
          c2 = !c2;
          ex_nv = 1'b1;
        end
        `MKC_KEY_DISC: dm = 2'h0;
        default: dm = 2'h2;
      endcase
    end
    #1;
    chk({dvl, mul, aih, rml}, {dv, mu, ah, rm}, "flags");
    chk({c2o, nv, ten, kl}, {c2, ex_nv, !mu, 1'b1}, "path_select_key save tx");
    chk({1'b0, two, one, sp}, {1'b0, dm == 2'h0, 1'b0, dm == 2'h2}, "demod");
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    {rst, fit, txa, txd, rxd, rxc} = 6'b111000;
    {dv, mu, ah, rm, c2, dm} = '0;
    void'($urandom(10240));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 120; i++) begin
      @(posedge clk);
      txd <= 1'($urandom);
      rxd <= 1'($urandom);
      rxc <= 1'($urandom);
      if (i % 8 == 0) begin
        fit <= 1'($urandom);
        repeat (6) @(posedge clk);
      end
      hit(keys[$urandom % 7]);
    end
    $display("random key test done");
    test_done();
  end
endmodule
bind mkc_keypad_ctrl mkc_keypad_asserts i_chk (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
  .KEY_STB_IN(KEY_STB_IN), .KEY_CODE_IN(KEY_CODE_IN), .DIV_FITTED_IN(DIV_FITTED_IN), .NV_SAVE_OUT(NV_SAVE_OUT),
  .TWO_TONE_DISCRIMINATOR_OUT(TWO_TONE_DISCRIMINATOR_OUT),
  .FIRST_TONE_ONLY_INDICATOR_OUT(FIRST_TONE_ONLY_INDICATOR_OUT),
  .SECOND_TONE_ONLY_INDICATOR_OUT(SECOND_TONE_ONLY_INDICATOR_OUT), .DIV_LED_OUT(DIV_LED_OUT),
  .MUTE_LED_OUT(MUTE_LED_OUT), .REMOTE_LED_OUT(REMOTE_LED_OUT), .AUTO_IDLE_HOLD_OUT(AUTO_IDLE_HOLD_OUT),
  .CHAN2_OUT(CHAN2_OUT));
`default_nettype wire
